// *** core/channel_combiner.sv ***
// Combines per-channel trigger hits by OR mask and AND mask
module channel_combiner
	import pwq_pkg::*;
(
	// Channel hits from the comparators
	input  wire logic [NUM_CH-1:0] chan_hit,
	// Masks
	input  wire logic [NUM_CH-1:0] or_mask,
	input  wire logic [NUM_CH-1:0] and_mask,
	input  wire logic [NUM_CH-1:0] mode_set,
	// Results
	output logic                   or_hit,
	output logic                   and_hit
);

	logic [NUM_CH-1:0] or_term;
	logic [NUM_CH-1:0] and_sel;
	logic [NUM_CH-1:0] and_ok;

	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_ch
		localparam logic fitted = (ch < int'(INSTALLED_CH));
		// A channel takes part only with its mode set and its OR-mask bit on;
		// a channel in the AND group votes only there, else AND would equal OR
		assign or_term[ch] = fitted && mode_set[ch] && or_mask[ch] && !and_mask[ch]
			&& chan_hit[ch];
		assign and_sel[ch] = fitted && mode_set[ch] && or_mask[ch] && and_mask[ch];
		assign and_ok[ch]  = !and_sel[ch] || chan_hit[ch];
	end

	assign or_hit  = |or_term;
	assign and_hit = (|and_sel) && (&and_ok);

endmodule // channel_combiner

// *** core/ext_trigger_pulsewidth_qualifier.sv ***
// Pulse-width qualified external trigger with channel trigger masks and APB registers
module ext_trigger_pulsewidth_qualifier
	import pwq_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic                   pready,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pslverr,
	// Trigger sources
	input  wire logic              ext_trig_in,
	input  wire logic [NUM_CH-1:0] chan_hit,
	// Acquisition control
	input  wire logic              acq_start,
	input  wire logic              acq_stop,
	input  wire logic              rec_done,
	// Trigger outputs
	output logic                   trig_out,
	output logic                   armed_out
);

	typedef struct packed
	{
		arm_state_e                     arm;
		logic                           trig;
		logic [DATA_W-1:0]              ext_mode;
		logic [THR_W-1:0]               threshold;
		logic [NUM_CH-1:0]              or_mask;
		logic [NUM_CH-1:0]              and_mask;
		logic                           ext_en;
		logic                           cherr;
		logic [NUM_CH-1:0][DATA_W-1:0]  chmode;
		logic                           ready;
		logic [DATA_W-1:0]              rdata;
		logic                           slverr;
	} top_s;

	top_s              state_q;
	top_s              state_d;
	logic [IDX_W-1:0]  idx;
	logic [CH_W-1:0]   ch_sel;
	logic              is_chmode;
	logic              ch_missing;
	logic              access;
	logic              complete;
	logic              wr_done;
	logic              bad_addr;
	logic              bad_write;
	logic [DATA_W-1:0] rd_mux;
	logic              sel_high;
	logic              want_longer;
	logic              want_shorter;
	logic              ext_hit;
	logic              or_hit;
	logic              and_hit;
	logic              trig_src;
	logic [NUM_CH-1:0] mode_set;

	// Decode of the external mode register
	assign sel_high     = state_q.ext_mode == MODE_POS_LONGER
		|| state_q.ext_mode == MODE_POS_SHORTER;
	assign want_longer  = state_q.ext_mode == MODE_POS_LONGER
		|| state_q.ext_mode == MODE_NEG_LONGER;
	assign want_shorter = state_q.ext_mode == MODE_POS_SHORTER
		|| state_q.ext_mode == MODE_NEG_SHORTER;

	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_mode
		assign mode_set[ch] = |state_q.chmode[ch];
	end

	pulse_width_meter u_meter
	(
		.mclk         (mclk),
		.nrst         (nrst),
		.ext_in       (ext_trig_in),
		.sel_high     (sel_high),
		.want_longer  (want_longer),
		.want_shorter (want_shorter),
		.threshold    (state_q.threshold),
		.qual_hit     (ext_hit)
	);

	channel_combiner u_comb
	(
		.chan_hit (chan_hit),
		.or_mask  (state_q.or_mask),
		.and_mask (state_q.and_mask),
		.mode_set (mode_set),
		.or_hit   (or_hit),
		.and_hit  (and_hit)
	);

	assign trig_src = (state_q.ext_en && ext_hit) || or_hit || and_hit;

	// Bus decode
	assign idx        = paddr[ADDR_W-1:2];
	assign is_chmode  = idx[IDX_W-1:CH_W] == IDX_CHMODE_BASE[IDX_W-1:CH_W];
	assign ch_sel     = idx[CH_W-1:0];
	assign ch_missing = is_chmode && ({1'b0, ch_sel} >= INSTALLED_CH);
	assign access     = psel && penable;
	assign complete   = access && state_q.ready;
	assign bad_addr   = !(is_chmode || idx == IDX_OR_MASK || idx == IDX_EXT_MODE
		|| idx == IDX_MAX_WIDTH || idx == IDX_THRESHOLD || idx == IDX_CTRL
		|| idx == IDX_STATUS || idx == IDX_AND_MASK);
	assign bad_write  = pwrite && (ch_missing
		|| idx == IDX_MAX_WIDTH
		|| (idx == IDX_THRESHOLD && (pwdata < THR_MIN || pwdata > THR_MAX)));
	assign wr_done    = complete && pwrite && !bad_addr && !bad_write;

	always_comb
	begin
		rd_mux = '0;
		if (is_chmode)
		begin
			if (!ch_missing)
				rd_mux = state_q.chmode[ch_sel];
		end
		else
		begin
			unique case (idx)
				IDX_OR_MASK:   rd_mux = {{(DATA_W-NUM_CH){1'b0}}, state_q.or_mask};
				IDX_AND_MASK:  rd_mux = {{(DATA_W-NUM_CH){1'b0}}, state_q.and_mask};
				IDX_EXT_MODE:  rd_mux = state_q.ext_mode;
				IDX_MAX_WIDTH: rd_mux = MAX_WIDTH;
				IDX_THRESHOLD: rd_mux = {{(DATA_W-THR_W){1'b0}}, state_q.threshold};
				IDX_CTRL:      rd_mux[CTRL_EXT_EN_BIT] = state_q.ext_en;
				IDX_STATUS:
				begin
					rd_mux[STAT_ARMED_BIT] = state_q.arm == ST_ARMED;
					rd_mux[STAT_FIRED_BIT] = state_q.arm == ST_FIRED;
					rd_mux[STAT_CHERR_BIT] = state_q.cherr;
				end
				default:       rd_mux = '0;
			endcase
		end
	end

	always_comb
	begin
		state_d = state_q;

		// APB: one wait state, answer registered in the first access cycle
		if (access && !state_q.ready)
		begin
			state_d.ready  = 1'b1;
			state_d.rdata  = pwrite ? '0 : rd_mux;
			state_d.slverr = bad_addr || bad_write;
		end
		else if (complete || !psel)
		begin
			state_d.ready  = 1'b0;
			state_d.rdata  = '0;
			state_d.slverr = 1'b0;
		end

		if (wr_done)
		begin
			if (is_chmode)
				state_d.chmode[ch_sel] = pwdata;
			else
			begin
				unique case (idx)
					IDX_OR_MASK:   state_d.or_mask   = pwdata[NUM_CH-1:0];
					IDX_AND_MASK:  state_d.and_mask  = pwdata[NUM_CH-1:0];
					IDX_EXT_MODE:  state_d.ext_mode  = pwdata;
					IDX_THRESHOLD: state_d.threshold = pwdata[THR_W-1:0];
					IDX_CTRL:      state_d.ext_en    = pwdata[CTRL_EXT_EN_BIT];
					IDX_STATUS:
					begin
						if (pwdata[STAT_CHERR_BIT])
							state_d.cherr = 1'b0;
					end
					default:       state_d.cherr = state_q.cherr;
				endcase
			end
		end

		// A rejected channel write sets the sticky flag; set beats clear
		if (complete && pwrite && ch_missing)
			state_d.cherr = 1'b1;

		// Arming sequence
		state_d.trig = 1'b0;
		unique case (state_q.arm)
			ST_IDLE:
			begin
				if (acq_start)
					state_d.arm = ST_ARMED;
			end
			ST_ARMED:
			begin
				if (trig_src)
				begin
					state_d.trig = 1'b1;
					state_d.arm  = ST_FIRED;
				end
			end
			ST_FIRED:
			begin
				if (rec_done)
					state_d.arm = ST_ARMED;
			end
			default:
				state_d.arm = ST_IDLE;
		endcase
		if (acq_stop)
		begin
			state_d.arm  = ST_IDLE;
			state_d.trig = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q           <= '0;
			state_q.arm       <= ST_IDLE;
			state_q.ext_mode  <= MODE_RESET;
			state_q.threshold <= THR_RESET;
			state_q.or_mask   <= MASK_RESET;
			state_q.and_mask  <= MASK_RESET;
		end
		else
			state_q <= state_d;
	end

	assign pready    = state_q.ready;
	assign prdata    = state_q.rdata;
	assign pslverr   = state_q.slverr;
	assign trig_out  = state_q.trig;
	assign armed_out = state_q.arm == ST_ARMED;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_thr_range;
		{16'h0000, state_q.threshold} >= THR_MIN;
	endproperty
	a_thr_range: assert property (p_thr_range) else $error("threshold below minimum");

	property p_thr_reject;
		complete && pwrite && idx == IDX_THRESHOLD && pwdata < THR_MIN |=> $stable(state_q.threshold);
	endproperty
	a_thr_reject: assert property (p_thr_reject) else $error("illegal threshold stored");

	property p_fire_armed;
		state_q.arm == ST_ARMED && trig_src && !acq_stop |=> trig_out ##1 !trig_out;
	endproperty
	a_fire_armed: assert property (p_fire_armed) else $error("armed trigger missed");

	property p_hold_off;
		state_q.arm != ST_ARMED |=> !trig_out;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("trigger while not armed");

	property p_rearm;
		trig_out && !rec_done ##1 !rec_done |-> state_q.arm == ST_FIRED || state_q.arm == ST_IDLE;
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearmed without recording end");

	property p_max_width;
		complete && !pwrite && idx == IDX_MAX_WIDTH |-> prdata == MAX_WIDTH && !pslverr;
	endproperty
	a_max_width: assert property (p_max_width) else $error("maximum width read wrong");

	property p_or_mask;
		or_hit |-> (chan_hit & state_q.or_mask & ~state_q.and_mask & mode_set) != '0;
	endproperty
	a_or_mask: assert property (p_or_mask) else $error("unmasked channel triggered");

	property p_and;
		and_hit |-> (chan_hit & state_q.and_mask & state_q.or_mask & mode_set
			& ~({NUM_CH{1'b1}} << INSTALLED_CH))
			== (state_q.and_mask & state_q.or_mask & mode_set & ~({NUM_CH{1'b1}} << INSTALLED_CH));
	endproperty
	a_and: assert property (p_and) else $error("AND trigger with channel missing");

	property p_missing_ch;
		complete && pwrite && ch_missing |-> pslverr ##1 state_q.cherr;
	endproperty
	a_missing_ch: assert property (p_missing_ch) else $error("missing channel write accepted");

	c_longer:  cover property (trig_out && want_longer);
	c_shorter: cover property (trig_out && want_shorter);
	c_cherr:   cover property (complete && ch_missing && pwrite);
	c_rearm:   cover property (state_q.arm == ST_FIRED && rec_done);
	c_and:     cover property (state_q.arm == ST_ARMED && and_hit);

endmodule // ext_trigger_pulsewidth_qualifier

// *** core/pulse_width_meter.sv ***
// Width counter for pulses of one polarity on the external trigger input
module pulse_width_meter
	import pwq_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Sampled trigger input
	input  wire logic             ext_in,
	// Configuration
	input  wire logic             sel_high,
	input  wire logic             want_longer,
	input  wire logic             want_shorter,
	input  wire logic [THR_W-1:0] threshold,
	// Qualified pulse, one cycle
	output logic                  qual_hit
);

	typedef struct packed
	{
		logic             prev;
		logic [CNT_W-1:0] count;
	} meter_s;

	meter_s state_q;
	meter_s state_d;
	logic   active;
	logic   prev_active;

	always_comb
	begin
		state_d     = state_q;
		active      = sel_high ? ext_in : ~ext_in;
		prev_active = sel_high ? state_q.prev : ~state_q.prev;
		state_d.prev = ext_in;
		if (active)
		begin
			if (!prev_active)
				state_d.count = CNT_ONE;
			else if (state_q.count != CNT_SAT)
				state_d.count = state_q.count + CNT_ONE;
		end
		// Longer: fire once, when the count first passes the threshold
		qual_hit = (want_longer && active && state_d.count == ({1'b0, threshold} + CNT_ONE))
			|| (want_shorter && !active && prev_active
			&& state_q.count < {1'b0, threshold});
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_longer_len;
		qual_hit && want_longer |-> state_q.count >= {1'b0, threshold} && prev_active;
	endproperty
	a_longer_len: assert property (p_longer_len) else $error("longer hit before width reached");

	property p_shorter_len;
		qual_hit && want_shorter && !want_longer |-> state_q.count < {1'b0, threshold} && !active;
	endproperty
	a_shorter_len: assert property (p_shorter_len) else $error("shorter hit on too long pulse");

	property p_polarity;
		qual_hit && want_longer |-> ext_in == sel_high;
	endproperty
	a_polarity: assert property (p_polarity) else $error("hit on wrong polarity");

endmodule // pulse_width_meter

// *** inc/pwq_pkg.sv ***
// Constants, register map and types for the external trigger pulse-width qualifier
package pwq_pkg;

	localparam int unsigned ADDR_W       = 18;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned IDX_W        = 16;
	localparam int unsigned NUM_CH       = 16;
	localparam int unsigned CH_W         = 4;
	localparam int unsigned CNT_W        = 17;
	localparam int unsigned THR_W        = 16;

	// Number of analog channels fitted on this build
	localparam logic [CH_W:0] INSTALLED_CH = 5'h04;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_OR_MASK    = 16'h9e0c;
	localparam logic [IDX_W-1:0] IDX_EXT_MODE   = 16'h9e3e;
	localparam logic [IDX_W-1:0] IDX_MAX_WIDTH  = 16'haca8;
	localparam logic [IDX_W-1:0] IDX_THRESHOLD  = 16'hacb2;
	localparam logic [IDX_W-1:0] IDX_CTRL       = 16'h9f10;
	localparam logic [IDX_W-1:0] IDX_STATUS     = 16'h9f11;
	localparam logic [IDX_W-1:0] IDX_AND_MASK   = 16'h9f12;
	localparam logic [IDX_W-1:0] IDX_CHMODE_BASE = 16'h9f00;

	// External mode codes
	localparam logic [DATA_W-1:0] MODE_POS_LONGER  = 32'h0400_0001;
	localparam logic [DATA_W-1:0] MODE_POS_SHORTER = 32'h0200_0001;
	localparam logic [DATA_W-1:0] MODE_NEG_LONGER  = 32'h0400_0002;
	localparam logic [DATA_W-1:0] MODE_NEG_SHORTER = 32'h0200_0002;

	// Width limits and reset values
	localparam logic [DATA_W-1:0] THR_MIN        = 32'h0000_0002;
	localparam logic [DATA_W-1:0] THR_MAX        = 32'h0000_ffff;
	localparam logic [THR_W-1:0]  THR_RESET      = 16'h0002;
	localparam logic [DATA_W-1:0] MAX_WIDTH      = 32'h0000_ffff;
	localparam logic [DATA_W-1:0] MODE_RESET     = 32'h0000_0000;
	localparam logic [NUM_CH-1:0] MASK_RESET     = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ONE        = 17'h0_0001;
	localparam logic [CNT_W-1:0]  CNT_SAT        = 17'h1_ffff;

	// Control and status bit positions
	localparam int unsigned CTRL_EXT_EN_BIT  = 0;
	localparam int unsigned STAT_ARMED_BIT   = 0;
	localparam int unsigned STAT_FIRED_BIT   = 1;
	localparam int unsigned STAT_CHERR_BIT   = 2;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_FIRED = 3'b100
	} arm_state_e;

endpackage

// *** test/ext_trigger_pulsewidth_qualifier_tb.sv ***
// Self-checking testbench for the pulse-width qualified trigger
module ext_trigger_pulsewidth_qualifier_tb
	import pwq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int THR = 4;

	logic              mclk;
	logic              nrst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic              pready;
	logic [DATA_W-1:0] prdata;
	logic              pslverr;
	logic              ext_trig_in;
	logic [NUM_CH-1:0] chan_hit;
	logic              acq_start;
	logic              acq_stop;
	logic              rec_done;
	logic              trig_out;
	logic              armed_out;
	logic [DATA_W-1:0] rd;
	logic              err;
	int                n_tests;
	int                n_mismatch;

	ext_trigger_pulsewidth_qualifier u_ext_trigger_pulsewidth_qualifier
	(
		.mclk        (mclk),
		.nrst        (nrst),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.pready      (pready),
		.prdata      (prdata),
		.pslverr     (pslverr),
		.ext_trig_in (ext_trig_in),
		.chan_hit    (chan_hit),
		.acq_start   (acq_start),
		.acq_stop    (acq_stop),
		.rec_done    (rec_done),
		.trig_out    (trig_out),
		.armed_out   (armed_out)
	);

	trig_source u_trig_source
	(
		.mclk        (mclk),
		.ext_trig_in (ext_trig_in)
	);

	initial
	begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
		int i;
		@(posedge mclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (pready !== 1'h1 && i < 50);
		rd = prdata;
		err = pslverr;
		chk("pready", 32'h0000_0001, {31'h0, pready});
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr_chk(input string name, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd,
		input logic e);
		apb(1'h1, idx, wd);
		chk(name, {31'h0, e}, {31'h0, err});
	endtask

	task automatic rd_chk(input string name, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp,
		input logic e);
		apb(1'h0, idx, 32'h0000_0000);
		chk(name, exp, rd);
		chk(name, {31'h0, e}, {31'h0, err});
	endtask

	// Strobe of start, stop and done in that bit order
	task automatic ctl(input logic [2:0] s);
		@(posedge mclk);
		{acq_start, acq_stop, rec_done} <= s;
		@(posedge mclk);
		{acq_start, acq_stop, rec_done} <= 3'h0;
		@(negedge mclk);
	endtask

	task automatic count_trig(input int span, output int n);
		n = 0;
		repeat (span)
		begin
			@(posedge mclk);
			if (trig_out === 1'h1)
				n++;
		end
	endtask

	task automatic pulse_trig(input string name, input logic lvl, input int len, input int exp);
		int n;
		fork
			u_trig_source.send(lvl, len);
			count_trig(len + 12, n);
		join
		chk(name, 32'(exp), 32'(n));
	endtask

	task automatic test_regs;
		rd_chk("mode reset", IDX_EXT_MODE, MODE_RESET, 1'h0);
		rd_chk("max width", IDX_MAX_WIDTH, MAX_WIDTH, 1'h0);
		wr_chk("max width write", IDX_MAX_WIDTH, 32'h0000_1234, 1'h1);
		rd_chk("max width kept", IDX_MAX_WIDTH, MAX_WIDTH, 1'h0);
		rd_chk("unmapped", 16'h0123, 32'h0000_0000, 1'h1);
		wr_chk("thr below", IDX_THRESHOLD, THR_MIN - 1, 1'h1);
		wr_chk("thr above", IDX_THRESHOLD, THR_MAX + 1, 1'h1);
		rd_chk("thr reset", IDX_THRESHOLD, THR_MIN, 1'h0);
		wr_chk("thr max", IDX_THRESHOLD, THR_MAX, 1'h0);
		rd_chk("thr max back", IDX_THRESHOLD, THR_MAX, 1'h0);
		$display("test_regs done");
	endtask

	// Every mode: equal, wrong and good widths, then one-shot and re-arm
	task automatic test_modes;
		logic [DATA_W-1:0] codes[4];
		logic              lvl;
		int                good;
		int                bad;
		codes = '{MODE_POS_LONGER, MODE_POS_SHORTER, MODE_NEG_LONGER, MODE_NEG_SHORTER};
		wr_chk("thr", IDX_THRESHOLD, 32'(THR), 1'h0);
		wr_chk("ext enable", IDX_CTRL, 32'h0000_0001, 1'h0);
		for (int k = 0; k < 4; k++)
		begin
			lvl = (k < 2);
			good = (k % 2 == 0) ? THR + 2 : THR - 2;
			bad = (k % 2 == 0) ? THR - 2 : THR + 2;
			ctl(3'h2);
			wr_chk("mode", IDX_EXT_MODE, codes[k], 1'h0);
			u_trig_source.rest(~lvl);
			repeat (3) @(posedge mclk);
			ctl(3'h4);
			chk("armed", 32'h0000_0001, {31'h0, armed_out});
			pulse_trig("equal width", lvl, THR, 0);
			pulse_trig("wrong width", lvl, bad, 0);
			pulse_trig("good width", lvl, good, 1);
			@(negedge mclk);
			chk("armed after fire", 32'h0000_0000, {31'h0, armed_out});
			pulse_trig("after fire", lvl, good, 0);
			ctl(3'h1);
			pulse_trig("rearmed", lvl, good, 1);
		end
		ctl(3'h2);
		$display("test_modes done");
	endtask

	task automatic chan_trig(input string name, input logic [NUM_CH-1:0] v, input int exp);
		int n;
		@(posedge mclk);
		chan_hit <= v;
		count_trig(4, n);
		chan_hit <= '0;
		chk(name, 32'(exp), 32'(n));
	endtask

	task automatic test_chan;
		wr_chk("ext disable", IDX_CTRL, 32'h0000_0000, 1'h0);
		wr_chk("chan 0 mode", IDX_CHMODE_BASE, 32'h0000_0001, 1'h0);
		wr_chk("missing chan", IDX_CHMODE_BASE + 16'(INSTALLED_CH), 32'h0000_0001, 1'h1);
		apb(1'h0, IDX_STATUS, 32'h0000_0000);
		chk("chan error flag", 32'h0000_0001, {31'h0, rd[STAT_CHERR_BIT]});
		wr_chk("chan error clear", IDX_STATUS, 32'h0000_0004, 1'h0);
		apb(1'h0, IDX_STATUS, 32'h0000_0000);
		chk("chan error cleared", 32'h0000_0000, {31'h0, rd[STAT_CHERR_BIT]});
		ctl(3'h4);
		chan_trig("masked off", 16'h0001, 0);
		wr_chk("or mask", IDX_OR_MASK, 32'h0000_0001, 1'h0);
		chan_trig("or hit", 16'h0001, 1);
		ctl(3'h1);
		wr_chk("chan 1 mode", IDX_CHMODE_BASE + 16'h0001, 32'h0000_0001, 1'h0);
		wr_chk("and mask", IDX_AND_MASK, 32'h0000_0003, 1'h0);
		wr_chk("or mask pair", IDX_OR_MASK, 32'h0000_0003, 1'h0);
		chan_trig("and one", 16'h0001, 0);
		chan_trig("and both", 16'h0003, 1);
		$display("test_chan done");
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		n_tests = 0;
		n_mismatch = 0;
		nrst = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = '0;
		pwdata = '0;
		chan_hit = '0;
		acq_start = 1'h0;
		acq_stop = 1'h0;
		rec_done = 1'h0;
		repeat (10) @(posedge mclk);
		nrst <= 1'h1;
		test_regs();
		test_modes();
		test_chan();
		finish_test();
	end

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		finish_test();
	end
endmodule // ext_trigger_pulsewidth_qualifier_tb

// *** test/trig_source.sv ***
// Model of the external TTL trigger source
module trig_source
(
	// Clock
	input  wire logic mclk,
	// Trigger line
	output logic      ext_trig_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial ext_trig_in = 1'h0;

	// Rest level sits opposite the measured polarity
	task automatic rest(input logic lvl);
		@(posedge mclk);
		ext_trig_in <= lvl;
	endtask

	// Holds the measured level for len samples, then returns to rest
	task automatic send(input logic lvl, input int len);
		@(posedge mclk);
		ext_trig_in <= lvl;
		repeat (len) @(posedge mclk);
		ext_trig_in <= ~lvl;
	endtask
endmodule // trig_source
